// file: hw/dcfs_params.svh
`ifndef DCFS_PARAMS_SVH
`define DCFS_PARAMS_SVH

// =====================================================================
// status register fields
`define DCFS_P_CH1_OFF      0
`define DCFS_P_CH2_OFF      1
`define DCFS_P_CH1_OC       2
`define DCFS_P_CH2_OC       3
`define DCFS_P_CH1_PBAD     4
`define DCFS_P_CH2_PBAD     5
`define DCFS_P_THERMAL      6
`define DCFS_P_SUPPLY_LOW   7
`define DCFS_S_CH1_CABLE    0
`define DCFS_S_CH2_CABLE    1
`define DCFS_S_CH1_TONE     2
`define DCFS_S_CH2_TONE     3

// =====================================================================
// reset values
`define DCFS_PRIMARY_RST    8'h03
`define DCFS_SECONDARY_RST  8'h00
`define DCFS_OFF_RST        2'h3

// =====================================================================
// timing counts
`define DCFS_OC_DETECT_DFLT 1000
`define DCFS_READ_BYTE_EDGES 4'h8

`endif

// file: hw/dcfs_pkg.sv
package dcfs_pkg;

	// =================================================================
	// status register layouts, msb first
	typedef struct packed {
		logic supply_low_flag;
		logic thermal_trip_flag;
		logic ch2_power_bad_flag;
		logic ch1_power_bad_flag;
		logic ch2_overcurrent_flag;
		logic ch1_overcurrent_flag;
		logic ch2_output_off_flag;
		logic ch1_output_off_flag;
	} dcfs_primary_t;

	typedef struct packed {
		logic [3:0] unused;
		logic       ch2_tone_seen_flag;
		logic       ch1_tone_seen_flag;
		logic       ch2_cable_open_flag;
		logic       ch1_cable_open_flag;
	} dcfs_secondary_t;

	// =================================================================
	// control bits from the control registers, index 0 is channel 1
	typedef struct packed {
		logic [1:0] channel_output_on;
		logic [1:0] overcurrent_cutoff_timer_enable;
		logic [1:0] cable_test_on;
	} dcfs_ctrl_t;

	// =================================================================
	// analog comparator levels, index 0 is channel 1
	typedef struct packed {
		logic [1:0] overcurrent;
		logic [1:0] below_85pct;
		logic [1:0] within_90pct;
		logic [1:0] above_21v;
		logic [1:0] below_19v95;
		logic [1:0] tone_present;
		logic       overtemp;
		logic       uvlo;
	} dcfs_sense_t;

endpackage : dcfs_pkg

// file: hw/dcfs_sync.sv
`timescale 1ns/1ns
// =====================================================================
// two flip-flop level synchroniser
module dcfs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : dcfs_sync

// file: hw/dcfs_bank.sv
`timescale 1ns/1ns
// Behaviour
// - latched faults hold until read after clearing
// - off flag set when disabled, held
// - reads alternate primary, secondary; start primary
// - no fault, outputs on: all zero
// - primary register bit order as defined
// - secondary register bit order, top unused
// - off flags set at reset; no interrupt
// - off flag clears at write end enabled
// - timed overcurrent trips output, sets flags
// - refresh on ninth edge; overcurrent cleared
// - timer off: overcurrent flag follows limit
// - overcurrent overheating: output off, thermal flag
// - power bad below 85, clear within 90
// - overtemp: both off, cleared at read
// - undervoltage: both off until control write
// - cable open above 21V, clear below 19.95V
// - cable flag clears when test off
// - tone flag follows tone at output
// - timer enable selects cut-off versus limit
// - output on bit switches channel output
// - cable test bit starts and stops test
`include "dcfs_params.svh"

module dcfs_bank
	import dcfs_pkg::*;
#(
	parameter int OC_DETECT_CYCLES = `DCFS_OC_DETECT_DFLT
) (
	// core clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// link clock and serial engine strobes on it
	input  wire logic            scl_clk,
	input  wire logic            link_read_start,
	input  wire logic            link_read_data,
	input  wire logic            link_write_end,
	// read transaction in progress, asynchronous level
	input  wire logic            link_read_active,
	// byte handed to the serial engine
	output logic      [7:0]      link_tx_byte,
	output logic                 link_tx_secondary,
	// control register bits and analog comparators
	input  wire dcfs_ctrl_t      ctrl,
	input  wire dcfs_sense_t     sense,
	// regulator enables and interrupt
	output logic      [1:0]      ch_output_enable,
	output logic                 irq,
	// status snapshot as seen by the link
	output dcfs_primary_t        status_primary,
	output dcfs_secondary_t      status_secondary
);

	// =================================================================
	// link domain: byte counting and register alternation
	logic [3:0] bit_cnt;
	logic       refresh_tog_l;
	logic       write_tog_l;

	// count read data edges; ninth edge ends the byte
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			bit_cnt <= 4'h0;
		end else if (link_read_start) begin
			bit_cnt <= 4'h0;
		end else if (link_read_data) begin
			if (bit_cnt == `DCFS_READ_BYTE_EDGES) begin
				bit_cnt <= 4'h0;
			end else begin
				bit_cnt <= bit_cnt + 4'h1;
			end
		end
	end

	// ninth edge of a read byte toggles a refresh event
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			refresh_tog_l <= 1'b0;
		end else if (link_read_data && !link_read_start &&
				bit_cnt == `DCFS_READ_BYTE_EDGES) begin
			refresh_tog_l <= ~refresh_tog_l;
		end
	end

	// next byte alternates registers, new read begins with primary
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			link_tx_secondary <= 1'b0;
			link_tx_byte      <= `DCFS_PRIMARY_RST;
		end else if (link_read_start) begin
			link_tx_secondary <= 1'b0;
			link_tx_byte      <= status_primary;
		end else if (link_read_data && bit_cnt == `DCFS_READ_BYTE_EDGES) begin
			link_tx_secondary <= ~link_tx_secondary;
			link_tx_byte      <= link_tx_secondary ? status_primary : status_secondary;
		end
	end

	// end of a write transaction as an event toggle
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			write_tog_l <= 1'b0;
		end else if (link_write_end) begin
			write_tog_l <= ~write_tog_l;
		end
	end

	// =================================================================
	// crossing into the core domain
	dcfs_sense_t sense_s;
	logic        read_busy;
	logic        refresh_tog_s;
	logic        write_tog_s;
	logic        refresh_tog_d;
	logic        write_tog_d;
	logic        refresh;
	logic        refresh_d;
	logic        write_end;

	dcfs_sync #(
		.W ($bits(dcfs_sense_t) + 3)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({sense, link_read_active, refresh_tog_l, write_tog_l}),
		.q   ({sense_s, read_busy, refresh_tog_s, write_tog_s})
	);

	// toggle edges become one-cycle events
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refresh_tog_d <= 1'b0;
			write_tog_d   <= 1'b0;
			refresh_d     <= 1'b0;
		end else begin
			refresh_tog_d <= refresh_tog_s;
			write_tog_d   <= write_tog_s;
			refresh_d     <= refresh;
		end
	end

	assign refresh   = refresh_tog_s ^ refresh_tog_d;
	assign write_end = write_tog_s ^ write_tog_d;

	// =================================================================
	// overcurrent detection timers
	logic [31:0] oc_timer [2];
	logic [1:0]  oc_trip;
	logic [1:0]  oc_timed;

	assign oc_timed = sense_s.overcurrent & ctrl.overcurrent_cutoff_timer_enable
			& ch_output_enable;

	for (genvar c = 0; c < 2; c++) begin : g_oc
		// run while a timed overcurrent persists
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				oc_timer[c] <= 32'h0;
			end else if (!oc_timed[c]) begin
				oc_timer[c] <= 32'h0;
			end else if (!oc_trip[c]) begin
				oc_timer[c] <= oc_timer[c] + 32'h1;
			end
		end
		assign oc_trip[c] = oc_timed[c] && oc_timer[c] == 32'(OC_DETECT_CYCLES - 1);
	end

	// =================================================================
	// latched chip-wide faults
	logic thermal_trip_flag;
	logic supply_low_flag;

	// set wins over the read-time clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			thermal_trip_flag <= 1'b0;
		end else if (sense_s.overtemp) begin
			thermal_trip_flag <= 1'b1;
		end else if (refresh) begin
			thermal_trip_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			supply_low_flag <= 1'b0;
		end else if (sense_s.uvlo) begin
			supply_low_flag <= 1'b1;
		end else if (refresh) begin
			supply_low_flag <= 1'b0;
		end
	end

	// =================================================================
	// per-channel flags
	logic [1:0] output_off_flag;
	logic [1:0] overcurrent_flag;
	logic [1:0] power_bad_flag;
	logic [1:0] cable_open_flag;
	logic [1:0] tone_seen_flag;
	logic [1:0] off_set;
	logic [1:0] off_clear;
	logic       chip_fault;

	assign chip_fault = thermal_trip_flag | supply_low_flag | sense_s.overtemp | sense_s.uvlo;
	// fault or command off forces the channel down
	assign off_set = oc_trip | {2{sense_s.overtemp | sense_s.uvlo}}
			| ~ctrl.channel_output_on;
	// re-enable only at a write end with no fault pending
	assign off_clear = {2{write_end & ~chip_fault}} & ctrl.channel_output_on
			& ~(overcurrent_flag & ctrl.overcurrent_cutoff_timer_enable);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			output_off_flag <= `DCFS_OFF_RST;
		end else begin
			output_off_flag <= off_set | (output_off_flag & ~off_clear);
		end
	end

	// regulator enables follow the off flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ch_output_enable <= 2'h0;
		end else begin
			ch_output_enable <= ctrl.channel_output_on & ~output_off_flag & ~off_set;
		end
	end

	for (genvar c = 0; c < 2; c++) begin : g_flags
		// latched with the timer on, following the limit with it off
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				overcurrent_flag[c] <= 1'b0;
			end else if (!ctrl.overcurrent_cutoff_timer_enable[c]) begin
				overcurrent_flag[c] <= sense_s.overcurrent[c] & ch_output_enable[c];
			end else if (oc_trip[c]) begin
				overcurrent_flag[c] <= 1'b1;
			end else if (refresh) begin
				overcurrent_flag[c] <= 1'b0;
			end
		end

		// hysteresis between the two voltage thresholds
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				power_bad_flag[c] <= 1'b0;
			end else if (!ch_output_enable[c] || sense_s.within_90pct[c]) begin
				power_bad_flag[c] <= 1'b0;
			end else if (sense_s.below_85pct[c]) begin
				power_bad_flag[c] <= 1'b1;
			end
		end

		// cable test comparator with hysteresis
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				cable_open_flag[c] <= 1'b0;
			end else if (!ctrl.cable_test_on[c] || sense_s.below_19v95[c]) begin
				cable_open_flag[c] <= 1'b0;
			end else if (sense_s.above_21v[c]) begin
				cable_open_flag[c] <= 1'b1;
			end
		end

		// tone seen follows the output tone level
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				tone_seen_flag[c] <= 1'b0;
			end else begin
				tone_seen_flag[c] <= sense_s.tone_present[c];
			end
		end
	end

	// =================================================================
	// live register images
	dcfs_primary_t   live_primary;
	dcfs_secondary_t live_secondary;

	always_comb begin
		live_primary                      = '0;
		live_primary.ch1_output_off_flag  = output_off_flag[0];
		live_primary.ch2_output_off_flag  = output_off_flag[1];
		live_primary.ch1_overcurrent_flag = overcurrent_flag[0];
		live_primary.ch2_overcurrent_flag = overcurrent_flag[1];
		live_primary.ch1_power_bad_flag   = power_bad_flag[0];
		live_primary.ch2_power_bad_flag   = power_bad_flag[1];
		live_primary.thermal_trip_flag    = thermal_trip_flag;
		live_primary.supply_low_flag      = supply_low_flag;
	end

	always_comb begin
		live_secondary                     = '0;
		live_secondary.ch1_cable_open_flag = cable_open_flag[0];
		live_secondary.ch2_cable_open_flag = cable_open_flag[1];
		live_secondary.ch1_tone_seen_flag  = tone_seen_flag[0];
		live_secondary.ch2_tone_seen_flag  = tone_seen_flag[1];
	end

	// =================================================================
	// snapshot held still while the link reads it, reloaded after the ninth edge of each byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_primary   <= `DCFS_PRIMARY_RST;
			status_secondary <= `DCFS_SECONDARY_RST;
		end else if (!read_busy || refresh_d) begin
			status_primary   <= live_primary;
			status_secondary <= live_secondary;
		end
	end

	// =================================================================
	// interrupt request from any flag but the off flags
	logic [9:0] irq_src;
	logic [9:0] irq_src_d;

	assign irq_src = {live_primary[7:2], live_secondary[3:0]};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_src_d <= 10'h000;
		end else begin
			irq_src_d <= irq_src;
		end
	end

	// a new flag wins over the clear after a read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (|(irq_src & ~irq_src_d)) begin
			irq <= 1'b1;
		end else if (refresh_d && !(|irq_src)) begin
			irq <= 1'b0;
		end
	end

endmodule : dcfs_bank

// file: testbench/dcfs_monitor.sv
`timescale 1ns/1ns
// =====================================================================
// port checker for the status bank
module dcfs_monitor
	import dcfs_pkg::*;
(
	// clocks and reset
	input wire logic            clk,
	input wire logic            rst,
	input wire logic            scl_clk,
	// link side
	input wire logic            link_read_start,
	input wire logic            link_read_data,
	input wire logic            link_read_active,
	input wire logic [7:0]      link_tx_byte,
	input wire logic            link_tx_secondary,
	// core side
	input wire dcfs_ctrl_t      ctrl,
	input wire dcfs_sense_t     sense,
	input wire logic [1:0]      ch_output_enable,
	input wire logic            irq,
	input wire dcfs_primary_t   status_primary,
	input wire dcfs_secondary_t status_secondary
);
	// ch1 on, cut-off timer off, no chip-wide fault
	sequence quiet_ch1;
		ctrl.channel_output_on[0] && !ctrl.overcurrent_cutoff_timer_enable[0]
			&& !sense.overtemp && !sense.uvlo;
	endsequence

	// =================================================================
	// link side byte order
	a_start_primary: assert property (@(posedge scl_clk) disable iff (rst)
		link_read_start |=> !link_tx_secondary && link_tx_byte == $past(status_primary))
		else $error("read did not open with primary");
	a_second_byte: assert property (@(posedge scl_clk) disable iff (rst)
		$rose(link_tx_secondary) |-> link_tx_byte == $past(status_secondary))
		else $error("secondary byte wrong");
	a_back_primary: assert property (@(posedge scl_clk) disable iff (rst)
		$fell(link_tx_secondary) |-> link_tx_byte == $past(status_primary))
		else $error("primary byte wrong");
	a_tx_hold: assert property (@(posedge scl_clk) disable iff (rst)
		!link_read_start && !link_read_data |=> $stable(link_tx_byte) && $stable(link_tx_secondary))
		else $error("tx byte moved outside read");

	// =================================================================
	// core side flags and enables
	a_unused_zero: assert property (@(posedge clk) disable iff (rst)
		status_secondary[7:4] == 4'h0) else $error("unused bits set");
	a_limit_holds: assert property (@(posedge clk) disable iff (rst)
		ch_output_enable[0] ##1 quiet_ch1 [*6] |-> ch_output_enable[0])
		else $error("output cut with timer off");
	a_irq_cause: assert property (@(posedge clk) disable iff (rst)
		$rose(irq) |-> ##[0:3] (status_primary[7:2] != 6'h00 || status_secondary[3:0] != 4'h0))
		else $error("irq without fault flag");
	a_cable_clear: assert property (@(posedge clk) disable iff (rst)
		(!ctrl.cable_test_on[0] && !link_read_active) [*8] |-> !status_secondary[0])
		else $error("cable flag with test off");
	a_off_disables: assert property (@(posedge clk) disable iff (rst)
		!ctrl.channel_output_on[1] [*4] |-> !ch_output_enable[1])
		else $error("ch2 on while commanded off");
endmodule : dcfs_monitor

bind dcfs_bank dcfs_monitor dcfs_monitor_inst (.*);

// file: testbench/dcfs_host.sv
`timescale 1ns/1ns
// =====================================================================
// host master model, link clock stands still between frames
module dcfs_host (
	// link strobes
	output logic            scl_clk,
	output logic            link_read_start,
	output logic            link_read_data,
	output logic            link_write_end,
	output logic            link_read_active,
	// byte from the bank
	input  wire logic [7:0] link_tx_byte
);
	logic [7:0] rx [0:3];

	// idle link
	initial begin
		scl_clk = 1'b0;
		{link_read_start, link_read_data, link_write_end, link_read_active} = 4'h0;
	end

	// one link clock, strobes set while low
	task step(input logic s, input logic d, input logic w);
		{link_read_start, link_read_data, link_write_end} = {s, d, w};
		#16 scl_clk = 1'b1;
		#16 scl_clk = 1'b0;
	endtask : step

	// read of n bytes, start first then nine edges a byte
	task rd(input int n);
		int b;
		link_read_active = 1'b1;
		#100;
		step(1'b1, 1'b0, 1'b0);
		for (b = 0; b < n; b++) begin
			rx[b] = link_tx_byte;
			repeat (9) step(1'b0, 1'b1, 1'b0);
		end
		link_read_data = 1'b0;
		link_read_active = 1'b0;
		#100;
	endtask : rd

	// reread, at most four times, until the given primary bit reads clear
	task poll(input int bit_pos);
		int k;
		for (k = 0; k < 4; k++) begin
			rd(1);
			if (rx[0][bit_pos] === 1'b0)
				break;
		end
	endtask : poll

	// end of a control write
	task wr();
		step(1'b0, 1'b0, 1'b1);
		link_write_end = 1'b0;
	endtask : wr
endmodule : dcfs_host

// file: testbench/dual_channel_fault_status_bank_tb.sv
`timescale 1ns/1ns
// =====================================================================
// bench for the status bank
module dual_channel_fault_status_bank_tb;
	import dcfs_pkg::*;

	typedef struct {
		dcfs_ctrl_t  c;
		dcfs_sense_t s;
		logic [7:0]  p;
		logic [7:0]  q;
	} dcfs_row_t;

	logic            clk = 1'b0;
	logic            rst;
	dcfs_ctrl_t      ctrl;
	dcfs_sense_t     sense;
	logic            scl_clk, link_read_start, link_read_data, link_write_end, link_read_active;
	logic [7:0]      link_tx_byte;
	logic            link_tx_secondary, irq;
	logic [1:0]      ch_output_enable;
	dcfs_primary_t   status_primary;
	dcfs_secondary_t status_secondary;
	int              error_cnt = 0;
	int              num_checks = 0;
	int              i;
	// steady cases, all with both outputs on
	dcfs_row_t       rows [13] = '{
		'{6'h3c, 14'h0330, 8'h00, 8'h00}, '{6'h3c, 14'h0830, 8'h20, 8'h00},
		'{6'h3c, 14'h0330, 8'h00, 8'h00}, '{6'h3c, 14'h0334, 8'h00, 8'h04},
		'{6'h3c, 14'h0338, 8'h00, 8'h08}, '{6'h3f, 14'h03c0, 8'h00, 8'h03},
		'{6'h3c, 14'h03c0, 8'h00, 8'h00}, '{6'h3f, 14'h0330, 8'h00, 8'h00},
		'{6'h38, 14'h1330, 8'h04, 8'h00}, '{6'h38, 14'h0330, 8'h00, 8'h00},
		'{6'h34, 14'h2330, 8'h08, 8'h00}, '{6'h34, 14'h0330, 8'h00, 8'h00},
		'{6'h3c, 14'h0430, 8'h10, 8'h00}};

	always #5 clk = ~clk;

	dcfs_bank #(.OC_DETECT_CYCLES(20)) dcfs_bank_inst (
		.clk(clk), .rst(rst), .scl_clk(scl_clk), .link_read_start(link_read_start),
		.link_read_data(link_read_data), .link_write_end(link_write_end),
		.link_read_active(link_read_active), .link_tx_byte(link_tx_byte),
		.link_tx_secondary(link_tx_secondary), .ctrl(ctrl), .sense(sense),
		.ch_output_enable(ch_output_enable), .irq(irq), .status_primary(status_primary),
		.status_secondary(status_secondary));

	dcfs_host dcfs_host_inst (
		.scl_clk(scl_clk), .link_read_start(link_read_start), .link_read_data(link_read_data),
		.link_write_end(link_write_end), .link_read_active(link_read_active),
		.link_tx_byte(link_tx_byte));

	// compare one value
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk

	// let sync and flag logic land
	task settle();
		repeat (10) @(negedge clk);
	endtask : settle

	// drive the core inputs
	task put(input logic [5:0] c, input logic [13:0] s);
		@(negedge clk);
		ctrl = c;
		sense = s;
		settle();
	endtask : put

	// counts and verdict
	task wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	// watchdog
	initial begin
		#500000;
		error_cnt++;
		wrap_up();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		ctrl = 6'h00;
		sense = 14'h0330;
		dcfs_host_inst.step(1'b0, 1'b0, 1'b0);
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		settle();
		chk("reset primary", 8'h03, status_primary);
		chk("reset secondary", 8'h00, status_secondary);
		chk("reset irq", 8'h00, {7'h00, irq});
		$display("test reset done");
		put(6'h3c, 14'h0330);
		dcfs_host_inst.wr();
		settle();
		chk("enable after write", 8'h03, {6'h00, ch_output_enable});
		for (i = 0; i < 13; i++) begin
			put(rows[i].c, rows[i].s);
			chk("row primary", rows[i].p, status_primary);
			chk("row secondary", rows[i].q, status_secondary);
			chk("row enable", 8'h03, {6'h00, ch_output_enable});
		end
		$display("test rows done");
		put(6'h38, 14'h1338);
		dcfs_host_inst.rd(3);
		chk("byte 1", 8'h04, dcfs_host_inst.rx[0]);
		chk("byte 2", 8'h08, dcfs_host_inst.rx[1]);
		chk("byte 3", 8'h04, dcfs_host_inst.rx[2]);
		dcfs_host_inst.rd(1);
		chk("new read", 8'h04, dcfs_host_inst.rx[0]);
		$display("test alternation done");
		put(6'h3c, 14'h0330);
		dcfs_host_inst.rd(1);
		settle();
		chk("follow flag read", 8'h00, status_primary);
		chk("irq idle", 8'h00, {7'h00, irq});
		put(6'h3c, 14'h1330);
		settle();
		settle();
		chk("trip primary", 8'h05, status_primary);
		chk("trip enable", 8'h02, {6'h00, ch_output_enable});
		chk("trip irq", 8'h01, {7'h00, irq});
		put(6'h3c, 14'h0330);
		chk("trip latched", 8'h05, status_primary);
		dcfs_host_inst.rd(1);
		settle();
		chk("trip read", 8'h05, dcfs_host_inst.rx[0]);
		chk("trip cleared", 8'h01, status_primary);
		chk("irq cleared", 8'h00, {7'h00, irq});
		dcfs_host_inst.wr();
		settle();
		chk("re-enabled", 8'h00, status_primary);
		$display("test overcurrent done");
		put(6'h3c, 14'h0332);
		chk("thermal", 8'h43, status_primary);
		chk("thermal enable", 8'h00, {6'h00, ch_output_enable});
		dcfs_host_inst.rd(1);
		settle();
		chk("thermal held", 8'h43, status_primary);
		put(6'h3c, 14'h0330);
		chk("thermal latched", 8'h43, status_primary);
		dcfs_host_inst.poll(6);
		settle();
		chk("thermal cleared", 8'h03, status_primary);
		dcfs_host_inst.wr();
		settle();
		chk("thermal back on", 8'h03, {6'h00, ch_output_enable});
		$display("test thermal done");
		put(6'h3c, 14'h0331);
		chk("supply low", 8'h83, status_primary);
		put(6'h3c, 14'h0330);
		chk("supply gone, off", 8'h00, {6'h00, ch_output_enable});
		dcfs_host_inst.poll(7);
		settle();
		chk("supply cleared", 8'h03, status_primary);
		chk("still off", 8'h00, {6'h00, ch_output_enable});
		dcfs_host_inst.wr();
		settle();
		chk("supply back on", 8'h03, {6'h00, ch_output_enable});
		$display("test undervoltage done");
		put(6'h1c, 14'h0330);
		chk("command off", 8'h02, status_primary);
		chk("command enable", 8'h01, {6'h00, ch_output_enable});
		chk("command irq", 8'h00, {7'h00, irq});
		$display("test command off done");
		@(negedge clk) rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		settle();
		chk("rerun primary", 8'h03, status_primary);
		chk("rerun enable", 8'h00, {6'h00, ch_output_enable});
		chk("rerun irq", 8'h00, {7'h00, irq});
		$display("test mid reset done");
		wrap_up();
	end
endmodule : dual_channel_fault_status_bank_tb
